// File: verif/pmx_ext_mem.sv
// External memory model on the multiplexed address/data bus of the port mux.
// Assumes control port pins 24 read/write and 26 latch strobe, P1/P2 as data.
`timescale 1ns/10ps
`default_nettype none
module pmx_ext_mem (
   input wire logic hclk,
   input wire logic [27:0] pins,
   input wire logic bus_strobe_n,
   output logic [15:0] rd_bus,
   output logic [15:0] wr_seen
);
   logic [23:0] lat_addr;
   logic [15:0] last = 16'h0000;
   logic drive;
   // Address latch: open while strobe high, holds while low
   always_latch begin
      if (pins[26]) begin
         lat_addr <= pins[23:0];
      end
   end
   // Drive only in a read data phase, otherwise show inverse of last value
   assign drive = ~bus_strobe_n & pins[24];
   assign rd_bus = drive ? (lat_addr[15:0] ^ 16'h3C96) : ~last;
   // Remember last driven value, capture written word
   always_ff @(posedge hclk) begin
      if (drive) begin
         last <= rd_bus;
      end
      if (~bus_strobe_n & ~pins[24]) begin
         wr_seen <= {pins[15:8], pins[23:16]};
      end
   end
endmodule : pmx_ext_mem
`default_nettype wire

// File: verif/pmx_top_test.sv
// Self-checking bench for the port function mux and its external bus.
// Assumes pmx_pkg, pmx_top and pmx_ext_mem are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module pmx_top_test;
   import pmx_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic mode_strap, bus_width_sel, bus_strobe_n;
   logic [31:0] haddr, hwdata, hrdata, periph_out, rv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [67:0] pin_drv, port_in, port_out, port_oe_n;
   logic [15:0] mem_rd, wr_seen;
   int n_errors = 0;
   int cmp_count = 0;
   assign hready = hreadyout;
   assign port_in = {pin_drv[67:24], mem_rd[7:0], mem_rd[15:8], pin_drv[7:0]};
   pmx_top u_pmx_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mode_strap(mode_strap),
      .bus_width_sel(bus_width_sel), .periph_out(periph_out), .port_in(port_in),
      .port_out(port_out), .port_oe_n(port_oe_n), .bus_strobe_n(bus_strobe_n));
   pmx_ext_mem u_pmx_ext_mem (.hclk(hclk), .pins(port_out[27:0]),
      .bus_strobe_n(bus_strobe_n), .rd_bus(mem_rd), .wr_seen(wr_seen));
   ////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // Hang guard
   initial begin
      repeat (4000) @(posedge hclk);
      n_errors++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////////
   task conclude;
      if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask : cyc
   // One AHB single transfer; read data lands in rv
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rv = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : ahb
   // Wait for a pin (68 = bus strobe) to reach a level, bounded
   task wait_bit(input string nm, input int b, input logic v);
      int k;
      k = 0;
      while ((b < 68 ? port_out[b] : bus_strobe_n) !== v && k < 20) begin
         cyc(1);
         k++;
      end
      chk(nm, 32'h0, {31'h0, k == 20});
   endtask : wait_bit
   // Clock output pin toggling every cycle and driven
   task clk_runs(input logic on);
      int t;
      logic p;
      t = 0;
      cyc(3);
      p = port_out[30];
      repeat (4) begin
         cyc(1);
         if (port_out[30] !== p) t++;
         p = port_out[30];
      end
      chk("clock pin", {31'h0, on}, {31'h0, t == 4 && port_oe_n[30] === 1'b0});
   endtask : clk_runs
   // One external bus cycle, judged on the pins and in the registers
   task ext(input logic [23:0] a, input logic [15:0] d, input logic rd, input logic wd,
            input logic w8, input logic [15:0] exp);
      bus_width_sel <= w8;
      ahb(1'b1, OFS_BADDR, {8'h00, a});
      ahb(1'b1, OFS_BWDATA, {16'h0000, d});
      ahb(1'b1, OFS_BCTRL, {29'h0, wd, rd, 1'b1});
      wait_bit("latch strobe", 26, 1'b1);
      chk("address", {8'h00, a}, {8'h00, port_out[23:0]});
      chk("rw", {31'h0, rd}, {31'h0, port_out[24]});
      chk("lane", {31'h0, ~(a[0] | (wd & ~w8))}, {31'h0, port_out[25]});
      wait_bit("strobe low", 68, 1'b0);
      if (w8) chk("mid port", {16'h0, a[15:8], 8'h00}, {16'h0, port_out[15:8], port_oe_n[15:8]});
      if (rd) chk("released", w8 ? 32'hFF : 32'hFFFF,
                  {16'h0, w8 ? 8'h00 : port_oe_n[15:8], port_oe_n[23:16]});
      else chk("wdata", w8 ? {24'h0, d[7:0]} : {16'h0, d},
               {16'h0, w8 ? 8'h00 : port_out[15:8], port_out[23:16]});
      wait_bit("strobe high", 68, 1'b1);
      chk("address back", {24'h0, a[23:16]}, {24'h0, port_out[23:16]});
      ahb(1'b0, OFS_BCTRL, 32'h0);
      chk("busy", 32'h0, {31'h0, rv[0]});
      ahb(1'b0, OFS_BRDATA, 32'h0);
      if (rd) chk("read data", {16'h0, exp}, rv);
      else chk("stored", w8 ? {24'h0, d[7:0]} : {16'h0, d},
               w8 ? {24'h0, wr_seen[7:0]} : {16'h0, wr_seen});
   endtask : ext
   ////////////////////////////////////////////////////////////////////////////
   // Single-chip pins, peripheral output, clock output
   task t_single;
      ahb(1'b1, 8'h44, 32'hFF);
      ahb(1'b1, 8'h40, 32'hA5);
      cyc(1);
      chk("port0", 32'hA500, {16'h0, port_out[7:0], port_oe_n[7:0]});
      ahb(1'b1, 8'h5C, 32'hFF);
      ahb(1'b0, 8'h5C, 32'h0);
      chk("ctrl dir", 32'hF, rv);
      ahb(1'b0, 8'h78, 32'h0);
      chk("pin read", 32'h3C, rv);
      ahb(1'b0, OFS_STAT, 32'h0);
      chk("stat", 32'h0, rv);
      ahb(1'b1, OFS_BCTRL, 32'h1);
      cyc(6);
      chk("no bus", 32'h1, {31'h0, bus_strobe_n});
      chk("peri off", 32'h1, {31'h0, port_oe_n[36]});
      ahb(1'b1, OFS_PSEL, 32'h1);
      cyc(2);
      chk("peri out", 32'h1, {30'h0, port_oe_n[36], port_out[36]});
      ahb(1'b1, OFS_MODE, 32'h80);
      clk_runs(1'b1);
   endtask : t_single
   // Memory expansion mode and its bus cycles
   task t_expand;
      ahb(1'b1, OFS_MODE, 32'h01);
      clk_runs(1'b0);
      chk("exp pins", 32'h10000000, {3'h0, port_out[27], port_oe_n[27:0]});
      ext(24'h123457, 16'hBEEF, 1'b0, 1'b1, 1'b0, 16'h0);
      ext(24'h00ABCE, 16'h0, 1'b1, 1'b1, 1'b0, 16'h9758);
      ext(24'hC0FFEE, 16'h0, 1'b1, 1'b0, 1'b1, 16'h0078);
      ext(24'h000102, 16'h0033, 1'b0, 1'b0, 1'b1, 16'h0);
   endtask : t_expand
   // Second reset with strap high: microprocessor mode
   task t_mpu;
      hresetn <= 1'b0;
      mode_strap <= 1'b1;
      bus_width_sel <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b1, OFS_MODE, 32'h0);
      ahb(1'b0, OFS_STAT, 32'h0);
      chk("strap mode", 32'h12, rv);
      clk_runs(1'b1);
      chk("mpu pins", 32'h0, {4'h0, port_oe_n[27:0]});
   endtask : t_mpu
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      mode_strap = 1'b0;
      bus_width_sel = 1'b1;
      periph_out = 32'h1;
      pin_drv = {60'h0, 8'h00};
      pin_drv[59:52] = 8'h3C;
      cyc(1);
      chk("reset oe", 32'hFFFFFFFF, port_oe_n[67:36]);
      chk("reset strobe", 32'h1, {31'h0, bus_strobe_n});
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_single();
      t_expand();
      t_mpu();
      conclude();
   end
endmodule : pmx_top_test
`default_nettype wire

// File: verilog/pmx_bus_seq.sv
// External bus cycle sequencer: address phase then strobe-low data phase.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/10ps
`default_nettype none
module pmx_bus_seq #(
   parameter int ADDR_N = pmx_pkg::ADDR_CYC,
   parameter int DATA_N = pmx_pkg::DATA_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   output var pmx_pkg::pmx_bstate_t state
);
   import pmx_pkg::*;
   logic [3:0] cnt;

   // Phase sequencing with per-phase cycle count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= BS_IDLE;
         cnt <= 4'h0;
      end else begin
         case (state)
            BS_IDLE: begin
               if (start) begin
                  state <= BS_ADDR;
                  cnt <= 4'h1;
               end
            end
            BS_ADDR: begin
               if (cnt == 4'(ADDR_N)) begin
                  state <= BS_DATA;
                  cnt <= 4'h1;
               end else begin
                  cnt <= cnt + 4'h1;
               end
            end
            BS_DATA: begin
               if (cnt == 4'(DATA_N)) begin
                  state <= BS_IDLE;
                  cnt <= 4'h0;
               end else begin
                  cnt <= cnt + 4'h1;
               end
            end
            default: begin
               state <= BS_IDLE;
               cnt <= 4'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_go;
      state == BS_IDLE && start;
   endsequence
   sequence s_cycle;
      (state == BS_ADDR)[*1] ##1 (state == BS_DATA)[*2] ##1 (state == BS_IDLE);
   endsequence
   property p_cycle_shape;
      @(posedge hclk) disable iff (!hresetn) s_go |=> s_cycle;
   endproperty
   a_cycle_shape: assert property (p_cycle_shape) else $error("bus phases out of order");
endmodule : pmx_bus_seq
`default_nettype wire

// File: verilog/pmx_clk_out.sv
// Clock output generator: half-rate square wave while selected.
// Assumes sel comes from registers in the hclk domain.
`timescale 1ns/10ps
`default_nettype none
module pmx_clk_out (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sel,
   output logic clk_out
);
   // Toggle from the edge after select is set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_out <= 1'b0;
      end else if (sel) begin
         clk_out <= ~clk_out;
      end else begin
         clk_out <= 1'b0;
      end
   end

   property p_toggle;
      @(posedge hclk) disable iff (!hresetn) sel ##1 sel |-> clk_out != $past(clk_out);
   endproperty
   a_toggle: assert property (p_toggle) else $error("clock output not toggling");
   property p_quiet;
      @(posedge hclk) disable iff (!hresetn) !sel |=> !clk_out;
   endproperty
   a_quiet: assert property (p_quiet) else $error("clock output runs unselected");
endmodule : pmx_clk_out
`default_nettype wire

// File: verilog/pmx_pkg.sv
// Constants, register map and carrier types of the port function mux.
// Assumes one clock domain (hclk) and an AHB-Lite register bus.
// Summary of operation
// - Single-chip mode: all 68 port pins work as general programmable I/O except pins given to a peripheral or the clock output.
// - Single-chip mode ignores the bus width select input completely.
// - Single-chip mode: control port is 4-bit I/O, other low ports 8-bit.
// - A pin given to a peripheral output is forced to output.
// - After reset with strap low every pin is general I/O, no peripheral selected.
// - Held in reset while reset is low; starts up on release.
// - Clock output starts at the end of the write setting select bit.
// - Expansion mode: select bit picks clock or I/O; microprocessor: always clock.
// - 40 general pins remain in expansion mode, 39 in microprocessor mode.
// - Expansion modes: three low ports output the 24-bit address.
// - Expansion modes: control port outputs the memory control signals.
// - Width select low: 16-bit bus, both bytes in one bus cycle.
// - 16-bit bus: middle port gives A15-A8 strobe high, odd byte strobe low.
// - High port gives A23-A16 strobe high, even data byte strobe low.
// - Width select high: 8-bit bus, only high port multiplexes data.
// - 8-bit bus: middle port carries address only.
// - Read/write output high for reads, low for writes.
// - Upper lane select low whenever an odd address is accessed.
package pmx_pkg;
   // Pin layout: P0..P8, control port only four pins wide
   localparam int PIN_CNT = 68;
   localparam int PORT_CNT = 9;
   localparam int PORT_BITS = 8;
   localparam int CTRL_PORT = 3;
   localparam int CTRL_BITS = 4;
   localparam int PIN_P1 = 8;
   localparam int PIN_P2 = 16;
   localparam int PIN_P3 = 24;
   localparam int PIN_P4 = 28;
   localparam int PIN_CLK = 30;
   localparam int PIN_PERI = 36;
   localparam int PERI_CNT = 32;
   // Control port bits in expansion modes
   localparam int CP_RW = 0;
   localparam int CP_ULS = 1;
   localparam int CP_ALE = 2;
   localparam int CP_GRANT = 3;
   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_BADDR = 8'h08;
   localparam logic [7:0] OFS_BWDATA = 8'h0C;
   localparam logic [7:0] OFS_BCTRL = 8'h10;
   localparam logic [7:0] OFS_BRDATA = 8'h14;
   localparam logic [7:0] OFS_PSEL = 8'h18;
   localparam logic [7:0] OFS_PORT = 8'h40;
   localparam logic [7:0] PORT_STRIDE = 8'h08;
   localparam logic [7:0] OFS_DIR = 8'h04;
   // Mode register fields
   localparam int MODE_W = 2;
   localparam int MODE_CLK_BIT = 7;
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_EXPAND = 2'h1;
   localparam logic [1:0] MODE_MPU = 2'h2;
   localparam logic [1:0] MODE_BAD = 2'h3;
   // Bus control and status bits
   localparam int BCTRL_GO = 0;
   localparam int BCTRL_READ = 1;
   localparam int BCTRL_WORD = 2;
   // External bus cycle lengths in hclk cycles
   localparam int ADDR_CYC = 1;
   localparam int DATA_CYC = 2;
   typedef enum logic [2:0] {
      BS_IDLE = 3'h1,
      BS_ADDR = 3'h2,
      BS_DATA = 3'h4
   } pmx_bstate_t;
   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic read;
      logic word;
   } pmx_breq_t;
   // First pin number of a port
   function automatic int port_base(input int p);
      return (p > CTRL_PORT) ? p * PORT_BITS - (PORT_BITS - CTRL_BITS) : p * PORT_BITS;
   endfunction : port_base
   // Pins in a port
   function automatic int port_width(input int p);
      return (p == CTRL_PORT) ? CTRL_BITS : PORT_BITS;
   endfunction : port_width
endpackage : pmx_pkg

// File: verilog/pmx_top.sv
// Port function mux: general I/O ports, multiplexed external bus, clock out.
// Assumes an AHB-Lite master on hclk and synchronous pin inputs.
`timescale 1ns/10ps
`default_nettype none
module pmx_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic mode_strap,
   input wire logic bus_width_sel,
   input wire logic [pmx_pkg::PERI_CNT-1:0] periph_out,
   input wire logic [pmx_pkg::PIN_CNT-1:0] port_in,
   output logic [pmx_pkg::PIN_CNT-1:0] port_out,
   output logic [pmx_pkg::PIN_CNT-1:0] port_oe_n,
   output logic bus_strobe_n
);
   import pmx_pkg::*;

   logic wr_pend;
   logic [7:0] wr_addr;
   logic sel_ok;
   logic [31:0] rd_val;
   logic strap_done;
   logic strap_lvl;
   logic [1:0] mode;
   logic clk_bit;
   logic [PIN_CNT-1:0] lat;
   logic [PIN_CNT-1:0] dir;
   logic [PIN_CNT-1:0] pin_rd;
   logic [PERI_CNT-1:0] psel;
   pmx_breq_t breq;
   logic [15:0] rdata_q;
   pmx_bstate_t bstate;
   logic ext;
   logic byte_eff;
   logic busy;
   logic start;
   logic clk_sel;
   logic clk_gen;
   logic [PIN_CNT-1:0] next_out;
   logic [PIN_CNT-1:0] next_oe_n;
   logic [PIN_CNT-1:0] psel_pins;

   // Port register hit for port p at field offset ofs
   function automatic logic port_hit(input logic [7:0] a, input int p, input logic [7:0] ofs);
      return a == 8'(OFS_PORT + 8'(p) * PORT_STRIDE + ofs);
   endfunction : port_hit

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: address phase capture, zero wait states
   assign sel_ok = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= sel_ok && hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // Read data registered in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (sel_ok && !hwrite) begin
            hrdata <= rd_val;
         end
      end
   end

   // Port reads show the latch on outputs, the pin on inputs
   assign pin_rd = (dir & lat) | (~dir & port_in);

   // Register read mux, unmapped reads give zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (haddr[7:0])
         OFS_MODE: rd_val = 32'({clk_bit, 5'h00, mode});
         OFS_STAT: rd_val = 32'({strap_lvl, busy, byte_eff, mode});
         OFS_BADDR: rd_val = 32'(breq.addr);
         OFS_BWDATA: rd_val = 32'(breq.wdata);
         OFS_BCTRL: rd_val = 32'({breq.word, breq.read, busy});
         OFS_BRDATA: rd_val = 32'(rdata_q);
         OFS_PSEL: rd_val = psel;
         default: rd_val = 32'h0000_0000;
      endcase
      for (int p = 0; p < PORT_CNT; p++) begin
         for (int b = 0; b < PORT_BITS; b++) begin
            if (b < port_width(p) && port_hit(haddr[7:0], p, 8'h00)) begin
               rd_val[b] = pin_rd[port_base(p) + b];
            end
            if (b < port_width(p) && port_hit(haddr[7:0], p, OFS_DIR)) begin
               rd_val[b] = dir[port_base(p) + b];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode strap taken on the first edge after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_done <= 1'b0;
         strap_lvl <= 1'b0;
         mode <= MODE_SINGLE;
         clk_bit <= 1'b0;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         strap_lvl <= mode_strap;
         mode <= mode_strap ? MODE_MPU : MODE_SINGLE;
      end else if (wr_pend && wr_addr == OFS_MODE) begin
         clk_bit <= hwdata[MODE_CLK_BIT];
         if (!strap_lvl && hwdata[MODE_W-1:0] != MODE_BAD) begin
            mode <= hwdata[MODE_W-1:0];
         end
      end
   end

   // Port latches, directions and peripheral selects
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lat <= '0;
         dir <= '0;
         psel <= '0;
      end else if (wr_pend) begin
         for (int p = 0; p < PORT_CNT; p++) begin
            for (int b = 0; b < PORT_BITS; b++) begin
               if (b < port_width(p) && port_hit(wr_addr, p, 8'h00)) begin
                  lat[port_base(p) + b] <= hwdata[b];
               end
               if (b < port_width(p) && port_hit(wr_addr, p, OFS_DIR)) begin
                  dir[port_base(p) + b] <= hwdata[b];
               end
            end
         end
         if (wr_addr == OFS_PSEL) begin
            psel <= hwdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // External bus request registers, frozen while a cycle runs
   assign ext = strap_done && mode != MODE_SINGLE;
   assign byte_eff = ext && bus_width_sel;
   assign busy = bstate != BS_IDLE || !bus_strobe_n;
   assign start = wr_pend && wr_addr == OFS_BCTRL && hwdata[BCTRL_GO] && ext && !busy;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         breq <= '0;
      end else if (wr_pend && !busy) begin
         if (wr_addr == OFS_BADDR) begin
            breq.addr <= hwdata[23:0];
         end
         if (wr_addr == OFS_BWDATA) begin
            breq.wdata <= hwdata[15:0];
         end
         if (wr_addr == OFS_BCTRL) begin
            breq.read <= hwdata[BCTRL_READ];
            breq.word <= hwdata[BCTRL_WORD];
         end
      end
   end

   pmx_bus_seq u_seq (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(start),
      .state(bstate)
   );

   // Strobe low for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_strobe_n <= 1'b1;
      end else begin
         bus_strobe_n <= bstate != BS_DATA;
      end
   end

   // Read data taken at the rising strobe edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 16'h0000;
      end else if (!bus_strobe_n && bstate != BS_DATA && breq.read) begin
         if (byte_eff) begin
            rdata_q <= {8'h00, port_in[PIN_P3-1:PIN_P2]};
         end else begin
            rdata_q <= {port_in[PIN_P2-1:PIN_P1], port_in[PIN_P3-1:PIN_P2]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock output select
   assign clk_sel = strap_done && (mode == MODE_MPU || clk_bit);

   pmx_clk_out u_clk (
      .hclk(hclk),
      .hresetn(hresetn),
      .sel(clk_sel),
      .clk_out(clk_gen)
   );

   assign psel_pins = {psel, {PIN_PERI{1'b0}}};

   // Pin function mux
   always_comb begin
      next_out = lat;
      next_oe_n = ~dir;
      for (int k = 0; k < PERI_CNT; k++) begin
         if (psel[k]) begin
            next_out[PIN_PERI + k] = periph_out[k];
            next_oe_n[PIN_PERI + k] = 1'b0;
         end
      end
      if (ext) begin
         next_out[PIN_P1-1:0] = breq.addr[7:0];
         next_out[PIN_P2-1:PIN_P1] = breq.addr[15:8];
         next_out[PIN_P3-1:PIN_P2] = breq.addr[23:16];
         next_oe_n[PIN_P3-1:0] = '0;
         if (bstate == BS_DATA) begin
            if (!byte_eff) begin
               next_out[PIN_P2-1:PIN_P1] = breq.wdata[15:8];
               next_oe_n[PIN_P2-1:PIN_P1] = {PORT_BITS{breq.read}};
            end
            next_out[PIN_P3-1:PIN_P2] = breq.wdata[7:0];
            next_oe_n[PIN_P3-1:PIN_P2] = {PORT_BITS{breq.read}};
         end
         next_out[PIN_P3 + CP_RW] = breq.read;
         next_out[PIN_P3 + CP_ULS] = !(breq.addr[0] || (breq.word && !byte_eff));
         next_out[PIN_P3 + CP_ALE] = bstate == BS_ADDR;
         next_out[PIN_P3 + CP_GRANT] = 1'b1;
         next_oe_n[PIN_P4-1:PIN_P3] = '0;
      end
      if (clk_sel) begin
         next_out[PIN_CLK] = clk_gen;
         next_oe_n[PIN_CLK] = 1'b0;
      end
      if (!strap_done) begin
         next_oe_n = '1;
      end
   end

   // Pin registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_out <= '0;
         port_oe_n <= '1;
      end else begin
         port_out <= next_out;
         port_oe_n <= next_oe_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_single_gpio;
      strap_done && !ext && !clk_sel && psel == '0 |=> port_oe_n == ~$past(dir);
   endproperty
   a_single_gpio: assert property (p_single_gpio) else $error("single-chip pin not plain I/O");
   property p_periph_force;
      strap_done |=> ((~port_oe_n) & $past(psel_pins)) == $past(psel_pins);
   endproperty
   a_periph_force: assert property (p_periph_force) else $error("peripheral pin not output");
   property p_strap_first;
      !strap_done |=> port_oe_n == '1;
   endproperty
   a_strap_first: assert property (p_strap_first) else $error("pin driven before strap taken");
   property p_addr_high;
      ext && bstate == BS_ADDR |=> port_out[PIN_P3-1:PIN_P2] == $past(breq.addr[23:16])
         && bus_strobe_n && port_out[PIN_P3 + CP_ALE];
   endproperty
   a_addr_high: assert property (p_addr_high) else $error("high port not on address");
   property p_read_release;
      ext && bstate == BS_DATA && breq.read |=> port_oe_n[PIN_P3-1:PIN_P2] == '1 && !bus_strobe_n;
   endproperty
   a_read_release: assert property (p_read_release) else $error("data port driven in read");
   property p_byte_mid;
      byte_eff && bstate == BS_DATA |=> port_out[PIN_P2-1:PIN_P1] == $past(breq.addr[15:8])
         && port_oe_n[PIN_P2-1:PIN_P1] == '0;
   endproperty
   a_byte_mid: assert property (p_byte_mid) else $error("middle port left address");
   property p_word_write;
      ext && !byte_eff && bstate == BS_DATA && !breq.read
         |=> port_out[PIN_P2-1:PIN_P1] == $past(breq.wdata[15:8])
         && port_out[PIN_P3-1:PIN_P2] == $past(breq.wdata[7:0]);
   endproperty
   a_word_write: assert property (p_word_write) else $error("16-bit write data wrong");
   property p_rw_level;
      ext && bstate != BS_IDLE |=> port_out[PIN_P3 + CP_RW] == $past(breq.read);
   endproperty
   a_rw_level: assert property (p_rw_level) else $error("read/write level wrong");
   property p_odd_lane;
      ext && bstate != BS_IDLE && breq.addr[0] |=> !port_out[PIN_P3 + CP_ULS];
   endproperty
   a_odd_lane: assert property (p_odd_lane) else $error("upper lane not selected");
   property p_mpu_clock;
      strap_done && mode == MODE_MPU |=> !port_oe_n[PIN_CLK];
   endproperty
   a_mpu_clock: assert property (p_mpu_clock) else $error("clock pin not driven");
endmodule : pmx_top
`default_nettype wire
